// ### logic/ezcl_pkg.sv
// Constants, types and offset decoding for the EEPROM zone configuration loader.
// Assumes 16-bit EEPROM words delivered one at a time by a separate serial reader.
package ezcl_pkg;

    localparam int unsigned CONT_BIT    = 15;
    localparam int unsigned OFF_MSB     = 14;
    localparam int unsigned OFF_LSB     = 8;
    localparam int unsigned FUNC_MSB    = 2;
    localparam int unsigned NUM_SLOTS   = 16;

    localparam logic [6:0] LCL_OFF_CTRL_B2   = 7'h02;

    localparam logic [6:0] ID_SEL_VENDOR_LO  = 7'h00;
    localparam logic [6:0] ID_SEL_VENDOR_HI  = 7'h01;
    localparam logic [6:0] ID_SEL_SSVID_LO   = 7'h02;
    localparam logic [6:0] ID_SEL_SSVID_HI   = 7'h03;

    localparam logic [6:0] CFG_VENDOR_LO     = 7'h00;
    localparam logic [6:0] CFG_VENDOR_HI     = 7'h01;
    localparam logic [6:0] CFG_PART_LO       = 7'h02;
    localparam logic [6:0] CFG_PART_HI       = 7'h03;
    localparam logic [6:0] CFG_STATUS_LO     = 7'h06;
    localparam logic [6:0] CFG_CLASS_LO      = 7'h09;
    localparam logic [6:0] CFG_CLASS_MID     = 7'h0A;
    localparam logic [6:0] CFG_CLASS_HI      = 7'h0B;
    localparam logic [6:0] CFG_HDR_TYPE      = 7'h0E;
    localparam logic [6:0] CFG_SSVID_LO      = 7'h2C;
    localparam logic [6:0] CFG_SSVID_HI      = 7'h2D;
    localparam logic [6:0] CFG_SUBSYS_LO     = 7'h2E;
    localparam logic [6:0] CFG_SUBSYS_HI     = 7'h2F;
    localparam logic [6:0] CFG_INT_PIN       = 7'h3D;
    localparam logic [6:0] CFG_PWR_LO        = 7'h42;
    localparam logic [6:0] CFG_PWR_HI        = 7'h43;

    localparam logic [7:0] STATUS_LO_MASK    = 8'h10;
    localparam logic [7:0] HDR_TYPE_MASK     = 8'h80;
    localparam logic [7:0] FULL_MASK         = 8'hFF;
    localparam logic [7:0] BYTE_RST          = 8'h00;
    localparam logic [2:0] FUNC_SERIAL       = 3'h0;
    localparam logic [2:0] FUNC_PARALLEL     = 3'h1;

    typedef enum logic [2:0] {
        ST_IDLE     = 3'b000,
        ST_LOCAL    = 3'b001,
        ST_IDENT    = 3'b010,
        ST_PCI_HDR  = 3'b011,
        ST_PCI_DATA = 3'b100,
        ST_DONE     = 3'b101
    } ezcl_state_e;

    // Config offset to storage slot; bit 4 set means the offset is stored.
    function automatic logic [4:0] cfg_slot(input logic [6:0] off);
        logic [4:0] s;
        s = 5'h00;
        unique case (off)
            CFG_VENDOR_LO: s = 5'h10;
            CFG_VENDOR_HI: s = 5'h11;
            CFG_PART_LO:   s = 5'h12;
            CFG_PART_HI:   s = 5'h13;
            CFG_STATUS_LO: s = 5'h14;
            CFG_CLASS_LO:  s = 5'h15;
            CFG_CLASS_MID: s = 5'h16;
            CFG_CLASS_HI:  s = 5'h17;
            CFG_HDR_TYPE:  s = 5'h18;
            CFG_SSVID_LO:  s = 5'h19;
            CFG_SSVID_HI:  s = 5'h1A;
            CFG_SUBSYS_LO: s = 5'h1B;
            CFG_SUBSYS_HI: s = 5'h1C;
            CFG_INT_PIN:   s = 5'h1D;
            CFG_PWR_LO:    s = 5'h1E;
            CFG_PWR_HI:    s = 5'h1F;
            default:       s = 5'h00;
        endcase
        return s;
    endfunction

    // Bits of a stored byte that the configuration zone may change.
    function automatic logic [7:0] cfg_wmask(input logic [6:0] off);
        logic [7:0] m;
        m = 8'h00;
        unique case (off)
            CFG_PART_LO, CFG_PART_HI, CFG_CLASS_LO, CFG_CLASS_MID, CFG_CLASS_HI,
            CFG_SUBSYS_LO, CFG_SUBSYS_HI, CFG_INT_PIN, CFG_PWR_LO, CFG_PWR_HI:
                m = FULL_MASK;
            CFG_STATUS_LO: m = STATUS_LO_MASK;
            CFG_HDR_TYPE:  m = HDR_TYPE_MASK;
            default:       m = 8'h00;
        endcase
        return m;
    endfunction

endpackage

// ### logic/ezcl_loader.sv
// Zone loader: walks local, identification and PCI configuration zones word by word.
// Assumes an external reader presents EEPROM words with valid/ready and zone enables from the header.
`timescale 1ns/1ps

// Summary of operation
// [R1] Local zone bit 15 continues or leaves zone
// [R2] Local word: offset 14:8, byte value 7:0
// [R3] Local offset equals BAR-relative register offset
// [R4] Local offset 0x02 hits control bits 23:16
// [R5] Only writable local registers take EEPROM values
// [R6] Identification writes update both functions together
// [R7] Identification bit 15 continues or leaves zone
// [R8] Selector 0x00/0x01/0x02/0x03 picks identification byte
// [R9] Selectors above defined ones are reserved
// [R10] Config zone never writes vendor identifiers
// [R11] Config zone parsed as per-function groups
// [R12] Header bit 15 one starts group, zero ends
// [R13] Header bits 2:0 select function, rest zero
// [R14] Config word bit 15 continues current function
// [R15] Config word offset 14:8, byte 7:0
// [R16] Offset 0x3D is interrupt pin register
// [R17] Part code and class code bytes writable
// [R18] Subsystem and power capability bytes writable
// [R19] Only bit 7 of offset 0x0E writable
// [R20] Unlisted offsets or reserved functions ignored
// [R21] Strict order, one word at a time, done
module ezcl_loader
    import ezcl_pkg::*;
#(
    parameter logic [127:0] LCL_WR_MASK = 128'h0000_0000_0000_0000_0000_0000_0000_00FF
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        start,
    input  wire logic        zone_local_en,
    input  wire logic        zone_ident_en,
    input  wire logic        zone_pci_en,
    input  wire logic        word_valid,
    input  wire logic [15:0] word_data,
    output logic             word_ready,
    output logic             busy,
    output logic             done,
    output logic             lcl_wr,
    output logic [6:0]       lcl_offset,
    output logic [7:0]       lcl_data,
    input  wire logic        rd_func,
    input  wire logic [6:0]  rd_offset,
    output logic [7:0]       rd_data
);

    typedef struct packed {
        ezcl_state_e              st;
        logic                     ident_en;
        logic                     pci_en;
        logic                     func;
        logic                     func_ok;
        logic                     done;
        logic                     lcl_wr;
        logic [6:0]               lcl_off;
        logic [7:0]               lcl_data;
        logic [7:0]               rd_data;
        logic [1:0][15:0][7:0]    cfg;
    } ezcl_regs_s;

    ezcl_regs_s q;
    ezcl_regs_s d;

    logic       acc;
    logic       cont;
    logic [6:0] off;
    logic [7:0] val;
    logic [4:0] slot;
    logic [7:0] wm;
    logic [4:0] rslot;

    assign cont = word_data[CONT_BIT];
    assign off  = word_data[OFF_MSB:OFF_LSB];
    assign val  = word_data[7:0];
    assign slot = cfg_slot(off);
    assign wm   = cfg_wmask(off);
    assign rslot = cfg_slot(rd_offset);

    // Ready only inside a zone; the next word is fetched after this one is applied [R21]
    assign word_ready = (q.st == ST_LOCAL) || (q.st == ST_IDENT) ||
                        (q.st == ST_PCI_HDR) || (q.st == ST_PCI_DATA);
    assign acc        = word_valid && word_ready;
    assign busy       = word_ready;
    assign done       = q.done;
    assign lcl_wr     = q.lcl_wr;
    assign lcl_offset = q.lcl_off;
    assign lcl_data   = q.lcl_data;
    assign rd_data    = q.rd_data;

    function automatic ezcl_state_e after_local(input logic id_en, input logic pc_en);
        if (id_en) begin
            return ST_IDENT;
        end else if (pc_en) begin
            return ST_PCI_HDR;
        end
        return ST_DONE;
    endfunction

    always_comb begin
        d = q;
        d.lcl_wr  = 1'b0;
        d.rd_data = rslot[4] ? q.cfg[rd_func][rslot[3:0]] : BYTE_RST;
        unique case (q.st)
            ST_IDLE, ST_DONE: begin
                if (start) begin
                    d.done     = 1'b0;
                    d.ident_en = zone_ident_en;
                    d.pci_en   = zone_pci_en;
                    d.func_ok  = 1'b0;
                    if (zone_local_en) begin
                        d.st = ST_LOCAL;
                    end else begin
                        d.st = after_local(zone_ident_en, zone_pci_en);
                    end
                    d.done = (d.st == ST_DONE);
                end
            end
            ST_LOCAL: begin
                if (acc) begin
                    // Offset passes through unchanged: same as BAR offset [R3], e.g. 0x02 [R4]
                    d.lcl_off  = off;                                   // [R2]
                    d.lcl_data = val;
                    d.lcl_wr   = LCL_WR_MASK[off];                      // [R5]
                    if (!cont) begin                                    // [R1]
                        d.st   = after_local(q.ident_en, q.pci_en);
                        d.done = (d.st == ST_DONE);                     // [R21]
                    end
                end
            end
            ST_IDENT: begin
                if (acc) begin
                    // Reserved selectors fall through untouched [R9]
                    for (int f = 0; f < 2; f++) begin                   // [R6]
                        unique case (off)                               // [R8]
                            ID_SEL_VENDOR_LO: d.cfg[f][4'h0] = val;
                            ID_SEL_VENDOR_HI: d.cfg[f][4'h1] = val;
                            ID_SEL_SSVID_LO:  d.cfg[f][4'h9] = val;
                            ID_SEL_SSVID_HI:  d.cfg[f][4'hA] = val;
                            default: ;
                        endcase
                    end
                    if (!cont) begin                                    // [R7]
                        d.st   = q.pci_en ? ST_PCI_HDR : ST_DONE;
                        d.done = !q.pci_en;
                    end
                end
            end
            ST_PCI_HDR: begin
                if (acc) begin
                    if (cont) begin                                     // [R12]
                        // Group opens; a reserved number silences it [R11] [R13] [R20]
                        d.st      = ST_PCI_DATA;
                        d.func    = word_data[0];
                        d.func_ok = (word_data[FUNC_MSB:0] == FUNC_SERIAL) ||
                                    (word_data[FUNC_MSB:0] == FUNC_PARALLEL);
                    end else begin
                        d.st   = ST_DONE;
                        d.done = 1'b1;                                  // [R21]
                    end
                end
            end
            ST_PCI_DATA: begin
                if (acc) begin
                    // Mask is zero for vendor and unlisted offsets [R10] [R17] [R18] [R19] [R20]
                    if (q.func_ok && slot[4]) begin                     // [R15] [R16]
                        d.cfg[q.func][slot[3:0]] = (q.cfg[q.func][slot[3:0]] & ~wm) | (val & wm);
                    end
                    if (!cont) begin                                    // [R14]
                        d.st = ST_PCI_HDR;
                    end
                end
            end
            default: begin
                d.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q          <= '0;
            q.st       <= ST_IDLE;
        end else begin
            q <= d;
        end
    end

    // Checks
    property p_lcl_write;
        @(posedge clk) disable iff (rst)
        (q.st == ST_LOCAL && acc && LCL_WR_MASK[off]) |=>
            (lcl_wr && lcl_offset == $past(off) && lcl_data == $past(val));
    endproperty
    a_lcl_write: assert property (p_lcl_write) else $error("local write missing"); // [R2]

    property p_lcl_protect;
        @(posedge clk) disable iff (rst)
        (q.st == ST_LOCAL && acc && !LCL_WR_MASK[off]) |=> !lcl_wr;
    endproperty
    a_lcl_protect: assert property (p_lcl_protect) else $error("protected local written"); // [R5]

    property p_lcl_ctrl;
        @(posedge clk) disable iff (rst)
        (q.st == ST_LOCAL && acc && off == LCL_OFF_CTRL_B2 && LCL_WR_MASK[off]) |=>
            (lcl_offset == LCL_OFF_CTRL_B2);
    endproperty
    a_lcl_ctrl: assert property (p_lcl_ctrl) else $error("control byte offset wrong"); // [R4]

    property p_lcl_leave;
        @(posedge clk) disable iff (rst)
        (q.st == ST_LOCAL && acc) |=> (q.st == ST_LOCAL) == $past(cont);
    endproperty
    a_lcl_leave: assert property (p_lcl_leave) else $error("local zone exit wrong"); // [R1]

    property p_ident_both;
        @(posedge clk) disable iff (rst)
        (q.st == ST_IDENT && acc && off == ID_SEL_VENDOR_HI) |=>
            (q.cfg[0][4'h1] == $past(val) && q.cfg[1][4'h1] == $past(val));
    endproperty
    a_ident_both: assert property (p_ident_both) else $error("ident not in both functions"); // [R6]

    property p_ident_cont;
        @(posedge clk) disable iff (rst)
        (q.st == ST_IDENT && acc && cont) |=> q.st == ST_IDENT;
    endproperty
    a_ident_cont: assert property (p_ident_cont) else $error("ident zone left early"); // [R7]

    property p_no_vendor;
        @(posedge clk) disable iff (rst)
        (q.st == ST_PCI_DATA && acc && (off == CFG_VENDOR_LO || off == CFG_VENDOR_HI)) |=>
            $stable(q.cfg[0][4'h0]) && $stable(q.cfg[0][4'h1]) &&
            $stable(q.cfg[1][4'h0]) && $stable(q.cfg[1][4'h1]);
    endproperty
    a_no_vendor: assert property (p_no_vendor) else $error("vendor written via config"); // [R10]

    property p_hdr_end;
        @(posedge clk) disable iff (rst)
        (q.st == ST_PCI_HDR && acc && !cont) |=> (done && !word_ready) [*2];
    endproperty
    a_hdr_end: assert property (p_hdr_end) else $error("config zone did not end"); // [R12]

    property p_data_last;
        @(posedge clk) disable iff (rst)
        (q.st == ST_PCI_DATA && acc && !cont) |=> q.st == ST_PCI_HDR;
    endproperty
    a_data_last: assert property (p_data_last) else $error("group did not close"); // [R14]

    property p_int_pin;
        @(posedge clk) disable iff (rst)
        (q.st == ST_PCI_DATA && acc && q.func_ok && off == CFG_INT_PIN) |=>
            q.cfg[$past(q.func)][4'hD] == $past(val);
    endproperty
    a_int_pin: assert property (p_int_pin) else $error("interrupt pin not written"); // [R16]

    property p_hdr_type;
        @(posedge clk) disable iff (rst)
        (q.st == ST_PCI_DATA && acc && q.func_ok && off == CFG_HDR_TYPE) |=>
            q.cfg[$past(q.func)][4'h8][6:0] == $past(q.cfg[q.func][4'h8][6:0]) &&
            q.cfg[$past(q.func)][4'h8][7] == $past(val[7]);
    endproperty
    a_hdr_type: assert property (p_hdr_type) else $error("header type mask wrong"); // [R19]

    property p_bad_func;
        @(posedge clk) disable iff (rst)
        (q.st == ST_PCI_DATA && acc && !q.func_ok) |=> $stable(q.cfg);
    endproperty
    a_bad_func: assert property (p_bad_func) else $error("reserved function written"); // [R20]

    property p_rd_unstored;
        @(posedge clk) disable iff (rst)
        !rslot[4] |=> rd_data == BYTE_RST;
    endproperty
    a_rd_unstored: assert property (p_rd_unstored) else $error("unstored offset reads nonzero"); // [R20]

    property p_ident_vendor_lo;
        @(posedge clk) disable iff (rst)
        (q.st == ST_IDENT && acc && off == ID_SEL_VENDOR_LO) |=>
            (q.cfg[0][4'h0] == $past(val) && q.cfg[1][4'h0] == $past(val));
    endproperty
    a_ident_vendor_lo: assert property (p_ident_vendor_lo) else $error("vendor low not shared"); // [R6]

    property p_ident_ssvid_lo;
        @(posedge clk) disable iff (rst)
        (q.st == ST_IDENT && acc && off == ID_SEL_SSVID_LO) |=>
            (q.cfg[0][4'h9] == $past(val) && q.cfg[1][4'h9] == $past(val));
    endproperty
    a_ident_ssvid_lo: assert property (p_ident_ssvid_lo) else $error("subsystem vendor low wrong"); // [R8]

    property p_ident_ssvid_hi;
        @(posedge clk) disable iff (rst)
        (q.st == ST_IDENT && acc && off == ID_SEL_SSVID_HI) |=>
            (q.cfg[0][4'hA] == $past(val) && q.cfg[1][4'hA] == $past(val));
    endproperty
    a_ident_ssvid_hi: assert property (p_ident_ssvid_hi) else $error("subsystem vendor high wrong"); // [R8]

    property p_ident_reserved;
        @(posedge clk) disable iff (rst)
        (q.st == ST_IDENT && acc && off > ID_SEL_SSVID_HI) |=> $stable(q.cfg);
    endproperty
    a_ident_reserved: assert property (p_ident_reserved) else $error("reserved selector wrote"); // [R9]

    property p_ident_exit;
        @(posedge clk) disable iff (rst)
        (q.st == ST_IDENT && acc && !cont) |=>
            ((q.st == ST_PCI_HDR) == $past(q.pci_en) && done == !$past(q.pci_en));
    endproperty
    a_ident_exit: assert property (p_ident_exit) else $error("ident zone exit wrong"); // [R7]

    property p_hdr_open;
        @(posedge clk) disable iff (rst)
        (q.st == ST_PCI_HDR && acc && cont) |=> (q.st == ST_PCI_DATA && q.func == $past(word_data[0]));
    endproperty
    a_hdr_open: assert property (p_hdr_open) else $error("group did not open"); // [R11]

    property p_func_sel;
        @(posedge clk) disable iff (rst)
        (q.st == ST_PCI_HDR && acc && cont) |=> q.func_ok == ($past(word_data[FUNC_MSB:0]) <= FUNC_PARALLEL);
    endproperty
    a_func_sel: assert property (p_func_sel) else $error("function number check wrong"); // [R13]

    property p_data_cont;
        @(posedge clk) disable iff (rst)
        (q.st == ST_PCI_DATA && acc && cont) |=> q.st == ST_PCI_DATA;
    endproperty
    a_data_cont: assert property (p_data_cont) else $error("group closed early"); // [R14]

    property p_part_lo;
        @(posedge clk) disable iff (rst)
        (q.st == ST_PCI_DATA && acc && q.func_ok && off == CFG_PART_LO) |=>
            q.cfg[$past(q.func)][4'h2] == $past(val);
    endproperty
    a_part_lo: assert property (p_part_lo) else $error("part code low not written"); // [R17]

    property p_class_hi;
        @(posedge clk) disable iff (rst)
        (q.st == ST_PCI_DATA && acc && q.func_ok && off == CFG_CLASS_HI) |=>
            q.cfg[$past(q.func)][4'h7] == $past(val);
    endproperty
    a_class_hi: assert property (p_class_hi) else $error("class code high not written"); // [R17]

    property p_subsys_hi;
        @(posedge clk) disable iff (rst)
        (q.st == ST_PCI_DATA && acc && q.func_ok && off == CFG_SUBSYS_HI) |=>
            q.cfg[$past(q.func)][4'hC] == $past(val);
    endproperty
    a_subsys_hi: assert property (p_subsys_hi) else $error("subsystem high not written"); // [R18]

    property p_pwr_hi;
        @(posedge clk) disable iff (rst)
        (q.st == ST_PCI_DATA && acc && q.func_ok && off == CFG_PWR_HI) |=>
            q.cfg[$past(q.func)][4'hF] == $past(val);
    endproperty
    a_pwr_hi: assert property (p_pwr_hi) else $error("power caps high not written"); // [R18]

    property p_other_func;
        @(posedge clk) disable iff (rst)
        (q.st == ST_PCI_DATA && acc) |=> ($past(q.func) ? $stable(q.cfg[0]) : $stable(q.cfg[1]));
    endproperty
    a_other_func: assert property (p_other_func) else $error("other function written"); // [R11]

    property p_done_quiet;
        @(posedge clk) disable iff (rst)
        done |-> !word_ready;
    endproperty
    a_done_quiet: assert property (p_done_quiet) else $error("words taken after done"); // [R21]

    property p_start_none;
        @(posedge clk) disable iff (rst)
        ((q.st == ST_IDLE || q.st == ST_DONE) && start && !zone_local_en && !zone_ident_en && !zone_pci_en)
            |=> done;
    endproperty
    a_start_none: assert property (p_start_none) else $error("empty load not done"); // [R21]

    c_local_to_ident: cover property (@(posedge clk) disable iff (rst)
        q.st == ST_LOCAL ##1 q.st == ST_IDENT);
    c_two_groups: cover property (@(posedge clk) disable iff (rst)
        q.st == ST_PCI_DATA ##1 q.st == ST_PCI_HDR ##1 q.st == ST_PCI_DATA);
    c_finish: cover property (@(posedge clk) disable iff (rst)
        q.st == ST_PCI_HDR ##1 q.st == ST_DONE);
    c_ident_to_cfg: cover property (@(posedge clk) disable iff (rst)
        q.st == ST_IDENT ##1 q.st == ST_PCI_HDR);
    c_reserved_group: cover property (@(posedge clk) disable iff (rst)
        q.st == ST_PCI_DATA && !q.func_ok && acc);

endmodule

// ### bench/ezcl_eeprom_model.sv
// EEPROM model for the zone loader: presents stored zone words in order, one word per handshake.
// Assumes the bench fills mem and word_count, then pulses rewind before each load.
`timescale 1ns/1ps
module ezcl_eeprom_model (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        rewind,
    input  wire logic        slow,
    input  wire logic        word_ready,
    output logic             word_valid,
    output logic [15:0]      word_data
);
    // Zone image as written by the bench, kept verbatim
    logic [15:0] mem [0:31];
    int          word_count;
    int          ptr;

    // Data toggles while no word is offered, so sampling without valid gives garbage
    always_ff @(posedge clk) begin
        if (rst || rewind) begin
            ptr        <= 0;
            word_valid <= 1'b0;
            word_data  <= 16'hFFFF;
        end else if (word_valid && word_ready) begin
            ptr        <= ptr + 1;
            word_valid <= !slow && (ptr + 1 < word_count);
            word_data  <= (!slow && ptr + 1 < word_count) ? mem[ptr + 1] : ~word_data;
        end else if (!word_valid && ptr < word_count) begin
            word_valid <= 1'b1;
            word_data  <= mem[ptr];
        end else if (!word_valid) begin
            word_data  <= ~word_data;
        end
    end
endmodule

// ### bench/test_ezcl_loader.sv
// Self-checking bench for the zone loader: runs loads from the EEPROM model and reads stored bytes back.
// Assumes the loader's default local write mask, offsets 0 to 7 writable.
`timescale 1ns/1ps
module test_ezcl_loader;
    import ezcl_pkg::*;
    logic        clk, rst, start, zone_local_en, zone_ident_en, zone_pci_en;
    logic        word_valid, word_ready, busy, done, lcl_wr, rd_func, rewind, slow;
    logic [15:0] word_data;
    logic [6:0]  lcl_offset, rd_offset;
    logic [7:0]  lcl_data, rd_data;
    logic [14:0] lcl_seen [$];
    int          bad_count, total_checks, cycles;

    ezcl_loader dut (.clk(clk), .rst(rst), .start(start), .zone_local_en(zone_local_en),
        .zone_ident_en(zone_ident_en), .zone_pci_en(zone_pci_en), .word_valid(word_valid),
        .word_data(word_data), .word_ready(word_ready), .busy(busy), .done(done), .lcl_wr(lcl_wr),
        .lcl_offset(lcl_offset), .lcl_data(lcl_data), .rd_func(rd_func), .rd_offset(rd_offset),
        .rd_data(rd_data));
    ezcl_eeprom_model eep (.clk(clk), .rst(rst), .rewind(rewind), .slow(slow),
        .word_ready(word_ready), .word_valid(word_valid), .word_data(word_data));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Local writes are one-cycle pulses, so they are logged as they appear
    always @(negedge clk) if (lcl_wr === 1'b1) lcl_seen.push_back({lcl_offset, lcl_data});

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            test_done();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic run(input logic [15:0] w [$], input logic le, input logic ie, input logic pe,
                       input logic sl);
        int n;
        foreach (w[i]) eep.mem[i] = w[i];
        eep.word_count = w.size();
        lcl_seen.delete();
        slow = sl;
        rewind = 1'b1;
        @(negedge clk);
        rewind = 1'b0;
        start = 1'b1;
        zone_local_en = le;
        zone_ident_en = ie;
        zone_pci_en = pe;
        @(negedge clk);
        start = 1'b0;
        check(done, !(le || ie || pe));
        check(busy, le || ie || pe);
        n = 0;
        while (done !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        check(n < 200, 1'b1);
        // The last pulse is logged on the same edge that ends the wait
        @(negedge clk);
    endtask

    task automatic rd(input logic f, input logic [6:0] off, input logic [7:0] exp);
        rd_func = f;
        rd_offset = off;
        @(negedge clk);
        check(rd_data, exp);
    endtask

    // Offset 0x0A lies outside the writable mask and must give no pulse
    task automatic t_local;
        run('{16'h8211, 16'h8A55, 16'h8707, 16'h0377}, 1'b1, 1'b0, 1'b0, 1'b0);
        check(lcl_seen.size(), 3);
        check(lcl_seen[0], {7'h02, 8'h11});
        check(lcl_seen[1], {7'h07, 8'h07});
        check(lcl_seen[2], {7'h03, 8'h77});
    endtask

    // Slow source; selector 0x04 is reserved and deliberately present
    task automatic t_ident;
        run('{16'h8112, 16'h8234, 16'h8356, 16'h8499, 16'h0078}, 1'b0, 1'b1, 1'b0, 1'b1);
        for (int f = 0; f < 2; f++) begin
            rd(f[0], 7'h00, 8'h78);
            rd(f[0], 7'h01, 8'h12);
            rd(f[0], 7'h2C, 8'h34);
            rd(f[0], 7'h2D, 8'h56);
        end
    endtask

    // Group for function 1, then a group with reserved function number 2
    task automatic t_all;
        run('{16'h0001, 16'h0011, 16'h8001, 16'hBD02, 16'h80AA, 16'h8EFF, 16'h8212, 16'h8B33,
              16'hAF44, 16'h4355, 16'h8002, 16'h3D07, 16'h0000}, 1'b1, 1'b1, 1'b1, 1'b0);
        check(lcl_seen.size(), 1);
        check(lcl_seen[0], {7'h00, 8'h01});
        rd(1'b1, 7'h3D, 8'h02);
        rd(1'b1, 7'h00, 8'h11);
        rd(1'b1, 7'h0E, 8'h80);
        rd(1'b1, 7'h02, 8'h12);
        rd(1'b1, 7'h0B, 8'h33);
        rd(1'b1, 7'h2F, 8'h44);
        rd(1'b1, 7'h43, 8'h55);
        rd(1'b0, 7'h3D, 8'h00);
        rd(1'b0, 7'h02, 8'h00);
        rd(1'b0, 7'h00, 8'h11);
        rd(1'b1, 7'h10, 8'h00);
    endtask

    // No zone enabled: load finishes at once; then a reset clears stored bytes
    task automatic t_none_reset;
        run('{16'h8000}, 1'b0, 1'b0, 1'b0, 1'b0);
        check(word_ready, 1'b0);
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        check(done, 1'b0);
        rd(1'b1, 7'h43, 8'h00);
    endtask

    initial begin
        rst = 1'b1;
        start = 1'b0;
        zone_local_en = 1'b0;
        zone_ident_en = 1'b0;
        zone_pci_en = 1'b0;
        rd_func = 1'b0;
        rd_offset = 7'h00;
        rewind = 1'b0;
        slow = 1'b0;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        t_local();
        t_ident();
        t_all();
        t_none_reset();
        test_done();
    end
endmodule
